// file: core/lacs_sequencer.sv
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps
// Overview of operation
// RQ1 - apply-then-print needs separate priming request first
// RQ2 - apply-then-print ends cycle printing next label
// RQ3 - parking honoured only for blow with apply-print
// RQ4 - park up: wait at start position
// RQ5 - park down: wait low, start blows immediately
// RQ6 - blow air held for blow duration
// RQ7 - roll-on holds pad down for dwell
// RQ8 - support air on after on-delay
// RQ9 - support air off after off-delay
// RQ10 - start delay before labelling process
// RQ11 - starts within lock-out are discarded
// RQ12 - signed peel offset shifts presentation
// RQ13 - job peel offset adds to configured
// RQ14 - no vacuum with check: error, backfeed
// RQ15 - check disabled skips error and backfeed
// RQ16 - keep suction check on in production
// RQ17 - start prints with vacuum, support, then lowers
// RQ18 - lower to sensor, vacuum off, return
// RQ19 - support off-delay resets to 270 ms
// RQ20 - timers advance on 10 ms tick
module lacs_sequencer
	import lacs_pkg::*;
#(
	parameter int unsigned TICK_DIV = TICK_CYCLES // cycles per tick
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	// apb slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// controller and sensor pins
	input  wire logic         i_start,
	input  wire logic         i_prime,
	input  wire logic         i_pos_sensor,
	input  wire logic         i_vac_sensor,
	// print engine
	input  wire logic         i_print_done,
	output lacs_print_t       o_print,
	// valves
	output lacs_valves_t      o_valves,
	// status
	output logic              o_pad_empty
);

	typedef enum {
		ST_IDLE,    // waiting for start or priming
		ST_DELAY,   // start delay
		ST_PRINT,   // printing, vacuum on
		ST_SUPOFF,  // support off-delay after pickup
		ST_CHECK,   // vacuum transfer check
		ST_LOWER,   // pad moving down
		ST_BLOW,    // blow dwell
		ST_ROLL,    // roll-on dwell
		ST_RAISE,   // pad back to start
		ST_ERROR    // pad empty, backfeed issued
	} lacs_state_t;

	lacs_state_t state_reg;     // sequencer state
	lacs_cfg_t   cfg_reg;       // software configuration
	logic signed [PEEL_W-1:0] peel_cfg_reg; // configured peel
	logic signed [PEEL_W-1:0] peel_job_reg; // per-job peel
	logic        primed_reg;    // label held on pad
	logic        parked_low_reg;// pad parked at labelling position
	logic        err_reg;       // pad-empty error flag
	logic        sup_wait_reg;  // support on-delay loaded for this print
	logic        bfeed_reg;     // backfeed pulse
	logic        start_d_reg;   // previous synced start
	logic        prime_d_reg;   // previous synced prime
	logic [31:0] tick_cnt_reg;  // tick prescaler
	logic        tick;          // 10 ms tick
	logic [3:0]  pins_s;        // synchronised pins
	logic        start_s, prime_s, pos_s, vac_s;
	logic        start_edge, prime_edge, start_ok;
	logic        t_load, t_done, lock_load, lock_done, sup_load, sup_done;
	logic [TIME_W-1:0] t_value;
	logic        park_active;   // parking setting honoured
	logic        wr_en, rd_en, clr_err;
	logic        lock_busy;

	// pins cross from outside, two flops each
	lacs_sync #(.W(4)) u_sync (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_async ({i_start, i_prime, i_pos_sensor, i_vac_sensor}),
		.o_sync  (pins_s)
	);
	assign {start_s, prime_s, pos_s, vac_s} = pins_s;

	// rising edges of requests
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			start_d_reg <= 1'b0;
			prime_d_reg <= 1'b0;
		end else begin
			start_d_reg <= start_s;
			prime_d_reg <= prime_s;
		end
	end
	assign start_edge = start_s && !start_d_reg;
	assign prime_edge = prime_s && !prime_d_reg;

	// tick prescaler from system clock
	always_ff @(posedge i_clk) begin
		if (i_reset || tick) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h1;
		end
	end
	assign tick = (tick_cnt_reg == 32'(TICK_DIV - 1)); // [RQ20]

	// sequence step timer
	lacs_timer u_step (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_tick  (tick),
		.i_load  (t_load),
		.i_value (t_value),
		.o_done  (t_done)
	);

	// lock-out timer runs beside the sequence
	lacs_timer u_lock (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_tick  (tick),
		.i_load  (lock_load),
		.i_value (cfg_reg.lock),
		.o_done  (lock_done)
	);

	// support on-delay timer, separate so it overlaps printing
	lacs_timer u_sup (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_tick  (tick),
		.i_load  (sup_load),
		.i_value (cfg_reg.sup_on),
		.o_done  (sup_done)
	);

	// parking only for blow plus apply-print
	assign park_active = cfg_reg.aprint && cfg_reg.park_dn
		&& cfg_reg.method == LACS_BLOW; // [RQ3]

	// a start is only taken while idle and primed when needed
	assign lock_busy  = !lock_done;
	assign start_ok   = start_edge && !lock_busy
		&& state_reg == ST_IDLE
		&& (!cfg_reg.aprint || primed_reg) && !err_reg; // [RQ11]
	assign lock_load  = start_ok; // [RQ11]

	// step timer loads on entry to timed states
	always_comb begin
		t_load  = 1'b0;
		t_value = ZERO_TIME;
		case (state_reg)
			ST_IDLE: begin
				if (start_ok) begin
					t_load  = 1'b1;
					t_value = cfg_reg.start_dly; // [RQ10]
				end
			end
			ST_PRINT: begin
				if (i_print_done) begin
					t_load  = 1'b1;
					t_value = cfg_reg.sup_off; // [RQ9]
				end
			end
			ST_LOWER: begin
				if (pos_s) begin
					t_load  = 1'b1;
					t_value = (cfg_reg.method == LACS_ROLL)
						? cfg_reg.roll : cfg_reg.blow;
				end
			end
			ST_DELAY: begin
				// parked low: the blow dwell starts from here
				t_load  = t_done && parked_low_reg; // [RQ5]
				t_value = cfg_reg.blow; // [RQ6]
			end
			default: begin
				t_load  = 1'b0;
			end
		endcase
	end

	// support on-delay starts with the print release
	assign sup_load = (state_reg == ST_PRINT) && !sup_wait_reg;

	// main sequence
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (start_ok) begin
						state_reg <= ST_DELAY;
					end else if (prime_edge && cfg_reg.aprint
							&& !primed_reg && !err_reg) begin
						state_reg <= ST_PRINT; // [RQ1]
					end
				end
				ST_DELAY: begin
					if (t_done) begin
						if (cfg_reg.aprint) begin
							// label already held
							state_reg <= parked_low_reg
								? ST_BLOW : ST_LOWER; // [RQ4] [RQ5]
						end else begin
							state_reg <= ST_PRINT; // [RQ17]
						end
					end
				end
				ST_PRINT: begin
					if (i_print_done) begin
						state_reg <= ST_SUPOFF;
					end
				end
				ST_SUPOFF: begin
					if (t_done) begin
						state_reg <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					if (cfg_reg.vac_chk && !vac_s) begin
						state_reg <= ST_ERROR; // [RQ14]
					end else if (cfg_reg.aprint) begin
						// next label held; park or wait up
						state_reg <= park_active
							? ST_LOWER : ST_IDLE; // [RQ2] [RQ4]
					end else begin
						state_reg <= ST_LOWER; // [RQ17] [RQ15]
					end
				end
				ST_LOWER: begin
					if (pos_s) begin
						if (park_active && primed_reg) begin
							state_reg <= ST_IDLE; // parked low [RQ5]
						end else begin
							state_reg <= (cfg_reg.method == LACS_STAMP)
								? ST_RAISE
								: (cfg_reg.method == LACS_ROLL)
								? ST_ROLL : ST_BLOW; // [RQ18]
						end
					end
				end
				ST_BLOW: begin
					if (t_done) begin
						state_reg <= ST_RAISE; // [RQ6]
					end
				end
				ST_ROLL: begin
					if (t_done) begin
						state_reg <= ST_RAISE; // [RQ7]
					end
				end
				ST_RAISE: begin
					// apply-print closes with the next print
					state_reg <= cfg_reg.aprint ? ST_PRINT : ST_IDLE; // [RQ2]
				end
				ST_ERROR: begin
					if (clr_err) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// label-on-pad tracking for apply-print
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			primed_reg     <= 1'b0;
			parked_low_reg <= 1'b0;
		end else if (state_reg == ST_CHECK) begin
			primed_reg     <= cfg_reg.aprint && !(cfg_reg.vac_chk && !vac_s);
			parked_low_reg <= 1'b0;
		end else if (state_reg == ST_LOWER && pos_s && park_active
				&& primed_reg) begin
			parked_low_reg <= 1'b1;
		end else if (state_reg == ST_DELAY && t_done) begin
			primed_reg     <= 1'b0;
		end
	end

	// support on-delay marker; re-armed each print
	always_ff @(posedge i_clk) begin
		if (i_reset || state_reg != ST_PRINT) begin
			sup_wait_reg <= 1'b0;
		end else begin
			sup_wait_reg <= 1'b1;
		end
	end

	// pad-empty flag: set wins over clear
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			err_reg <= 1'b0;
		end else if (state_reg == ST_CHECK && cfg_reg.vac_chk && !vac_s)
			begin
			err_reg <= 1'b1; // [RQ14]
		end else if (clr_err) begin
			err_reg <= 1'b0;
		end
	end

	// one-cycle backfeed request on error
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			bfeed_reg <= 1'b0;
		end else begin
			bfeed_reg <= state_reg == ST_CHECK && cfg_reg.vac_chk
				&& !vac_s; // [RQ14] [RQ15]
		end
	end

	// valve outputs registered from state
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_valves <= '0;
		end else begin
			// vacuum holds the label from print until placed
			o_valves.vacuum  <= state_reg == ST_PRINT
				|| state_reg == ST_SUPOFF || state_reg == ST_CHECK
				|| state_reg == ST_DELAY && cfg_reg.aprint
				|| state_reg == ST_IDLE && primed_reg
				|| state_reg == ST_LOWER && (primed_reg || !pos_s); // [RQ18]
			o_valves.support <= state_reg == ST_PRINT && sup_wait_reg
				&& sup_done && !sup_load
				|| state_reg == ST_SUPOFF; // [RQ8] [RQ9]
			o_valves.blow    <= state_reg == ST_BLOW
				&& cfg_reg.method == LACS_BLOW; // [RQ6]
			// lift stays down while parked low
			o_valves.lift    <= state_reg == ST_LOWER
				|| state_reg == ST_BLOW || state_reg == ST_ROLL
				|| state_reg == ST_IDLE && parked_low_reg
				|| state_reg == ST_DELAY && parked_low_reg; // [RQ7]
		end
	end

	// print engine drive; peel sum saturation left to the engine
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_print <= '0;
		end else begin
			o_print.print    <= state_reg == ST_PRINT && !i_print_done;
			o_print.backfeed <= bfeed_reg;
			o_print.peel     <= peel_cfg_reg + peel_job_reg; // [RQ12] [RQ13]
		end
	end
	assign o_pad_empty = err_reg;

	// apb strobes, zero wait states
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && !penable && !pwrite;
	assign clr_err = wr_en && paddr == OFS_CMD && pwdata[CMD_CLR_ERR];
	assign pready  = 1'b1;

	// configuration writes
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			cfg_reg.method    <= lacs_method_t'(CTRL_RST[CTRL_MODE_LSB +: 2]);
			cfg_reg.aprint    <= CTRL_RST[CTRL_APRINT];
			cfg_reg.park_dn   <= CTRL_RST[CTRL_PARK_DN];
			cfg_reg.vac_chk   <= CTRL_RST[CTRL_VAC_CHK];
			cfg_reg.blow      <= ZERO_TIME;
			cfg_reg.roll      <= ZERO_TIME;
			cfg_reg.sup_on    <= ZERO_TIME;
			cfg_reg.sup_off   <= SUP_OFF_RST; // [RQ19]
			cfg_reg.start_dly <= ZERO_TIME;
			cfg_reg.lock      <= ZERO_TIME;
			peel_cfg_reg      <= '0;
			peel_job_reg      <= '0;
		end else if (wr_en) begin
			if (paddr == OFS_CTRL) begin
				cfg_reg.method  <= lacs_method_t'(pwdata[CTRL_MODE_LSB +: 2]);
				cfg_reg.aprint  <= pwdata[CTRL_APRINT];
				cfg_reg.park_dn <= pwdata[CTRL_PARK_DN];
				cfg_reg.vac_chk <= pwdata[CTRL_VAC_CHK];
			end else if (paddr == OFS_BLOW) begin
				cfg_reg.blow <= pwdata[TIME_W-1:0];
			end else if (paddr == OFS_ROLL) begin
				cfg_reg.roll <= pwdata[TIME_W-1:0];
			end else if (paddr == OFS_SUP_ON) begin
				cfg_reg.sup_on <= pwdata[TIME_W-1:0];
			end else if (paddr == OFS_SUP_OFF) begin
				cfg_reg.sup_off <= pwdata[TIME_W-1:0];
			end else if (paddr == OFS_START_DLY) begin
				cfg_reg.start_dly <= pwdata[TIME_W-1:0];
			end else if (paddr == OFS_LOCK) begin
				cfg_reg.lock <= pwdata[TIME_W-1:0];
			end else if (paddr == OFS_PEEL_CFG) begin
				peel_cfg_reg <= pwdata[PEEL_W-1:0];
			end else if (paddr == OFS_PEEL_JOB) begin
				peel_job_reg <= pwdata[PEEL_W-1:0];
			end
		end
	end

	// read data captured in setup, stable through access
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= 1'b0;
			prdata  <= '0;
			if (paddr == OFS_CTRL) begin
				prdata[4:0] <= {cfg_reg.vac_chk, cfg_reg.park_dn,
					cfg_reg.aprint, cfg_reg.method};
			end else if (paddr == OFS_BLOW) begin
				prdata[TIME_W-1:0] <= cfg_reg.blow;
			end else if (paddr == OFS_ROLL) begin
				prdata[TIME_W-1:0] <= cfg_reg.roll;
			end else if (paddr == OFS_SUP_ON) begin
				prdata[TIME_W-1:0] <= cfg_reg.sup_on;
			end else if (paddr == OFS_SUP_OFF) begin
				prdata[TIME_W-1:0] <= cfg_reg.sup_off;
			end else if (paddr == OFS_START_DLY) begin
				prdata[TIME_W-1:0] <= cfg_reg.start_dly;
			end else if (paddr == OFS_LOCK) begin
				prdata[TIME_W-1:0] <= cfg_reg.lock;
			end else if (paddr == OFS_PEEL_CFG) begin
				prdata[PEEL_W-1:0] <= peel_cfg_reg;
			end else if (paddr == OFS_PEEL_JOB) begin
				prdata[PEEL_W-1:0] <= peel_job_reg;
			end else if (paddr == OFS_STATUS) begin
				// state code, error, primed, parked, lock busy
				prdata[7:0] <= {lock_busy, parked_low_reg, primed_reg,
					err_reg, 4'(state_reg)};
			end else if (paddr != OFS_CMD) begin
				pslverr <= !rd_en ? 1'b1 : 1'b1; // unmapped
			end
		end
	end

endmodule : lacs_sequencer

// file: inc/lacs_pkg.sv
package lacs_pkg;

	// clock and tick timing
	localparam int unsigned CLK_HZ        = 100000000; // system clock rate
	localparam int unsigned TICK_MS       = 10;        // timer tick period
	localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned TIME_W        = 9;         // ticks, up to 511

	// register byte offsets
	localparam logic [7:0] OFS_CTRL       = 8'h00; // modes and checks
	localparam logic [7:0] OFS_BLOW       = 8'h04; // blow duration
	localparam logic [7:0] OFS_ROLL       = 8'h08; // roll-on dwell
	localparam logic [7:0] OFS_SUP_ON     = 8'h0C; // support air on-delay
	localparam logic [7:0] OFS_SUP_OFF    = 8'h10; // support air off-delay
	localparam logic [7:0] OFS_START_DLY  = 8'h14; // start delay
	localparam logic [7:0] OFS_LOCK       = 8'h18; // lock-out duration
	localparam logic [7:0] OFS_PEEL_CFG   = 8'h1C; // configured peel offset
	localparam logic [7:0] OFS_PEEL_JOB   = 8'h20; // per-job peel offset
	localparam logic [7:0] OFS_STATUS     = 8'h24; // state and error flags
	localparam logic [7:0] OFS_CMD        = 8'h28; // clear-error command

	// control register fields
	localparam int unsigned CTRL_MODE_LSB = 0; // 2 bits: transfer method
	localparam int unsigned CTRL_APRINT   = 2; // apply-then-print
	localparam int unsigned CTRL_PARK_DN  = 3; // parking position down
	localparam int unsigned CTRL_VAC_CHK  = 4; // suction check enable

	// command register fields
	localparam int unsigned CMD_CLR_ERR   = 0; // clear pad-empty error

	// reset values, in ticks of 10 ms
	localparam logic [31:0] CTRL_RST      = 32'h0000_0010;
	localparam logic [TIME_W-1:0] SUP_OFF_RST = 9'h01B; // 270 ms
	localparam logic [TIME_W-1:0] ZERO_TIME   = 9'h000;
	localparam int unsigned PEEL_W        = 8; // signed, 0.1 mm steps

	// transfer methods
	typedef enum logic [1:0] {
		LACS_STAMP = 2'h0,
		LACS_BLOW  = 2'h1,
		LACS_ROLL  = 2'h2
	} lacs_method_t;

	// valve drive bundle
	typedef struct packed {
		logic vacuum;  // pad vacuum
		logic support; // supporting air
		logic blow;    // transfer blow air
		logic lift;    // lift cylinder down
	} lacs_valves_t;

	// print engine request bundle
	typedef struct packed {
		logic                     print;    // release one label print
		logic                     backfeed; // feed the strip back
		logic signed [PEEL_W-1:0] peel;     // summed peel offset
	} lacs_print_t;

	// configuration bundle
	typedef struct packed {
		lacs_method_t      method;
		logic              aprint;
		logic              park_dn;
		logic              vac_chk;
		logic [TIME_W-1:0] blow;
		logic [TIME_W-1:0] roll;
		logic [TIME_W-1:0] sup_on;
		logic [TIME_W-1:0] sup_off;
		logic [TIME_W-1:0] start_dly;
		logic [TIME_W-1:0] lock;
	} lacs_cfg_t;

endpackage : lacs_pkg

// file: core/lacs_timer.sv
`timescale 1ns/100ps
// tick-based down counter, loaded then counting down to zero
module lacs_timer
	import lacs_pkg::*;
#(
	parameter int unsigned W = TIME_W
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	// control
	input  wire logic         i_tick,
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_value,
	// status
	output logic              o_done
);

	logic [W-1:0] count_reg; // remaining ticks

	// load wins over counting, done once zero
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			count_reg <= '0;
		end else if (i_load) begin
			count_reg <= i_value;
		end else if (i_tick && count_reg != '0) begin
			count_reg <= count_reg - 1'b1;
		end
	end

	// a zero value ends at once; granularity is one tick
	assign o_done = count_reg == '0;

endmodule : lacs_timer

// file: core/lacs_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser for pins, one per bit
module lacs_sync #(
	parameter int unsigned W = 1
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	// data
	input  wire logic [W-1:0] i_async,
	output logic [W-1:0]      o_sync
);

	logic [W-1:0] meta_reg; // first stage, read only by second

	genvar b;
	generate
		for (b = 0; b < W; b++) begin : g_bit
			// per-bit double flop
			always_ff @(posedge i_clk) begin
				if (i_reset) begin
					meta_reg[b] <= 1'b0;
					o_sync[b]   <= 1'b0;
				end else begin
					meta_reg[b] <= i_async[b];
					o_sync[b]   <= meta_reg[b];
				end
			end
		end
	endgenerate

endmodule : lacs_sync

// file: test/lacs_partner.sv
`timescale 1ns/100ps
// far side model: print engine, lift travel and pad vacuum sensor
module lacs_partner
	import lacs_pkg::*;
(
	// clock
	input  wire logic    i_clk,
	// design drive
	input  lacs_print_t  i_print,
	input  lacs_valves_t i_valves,
	// scenario control
	input  wire logic    i_no_label,
	// sensors
	output logic         o_pos,
	output logic         o_vac,
	output logic         o_done
);
	logic [5:0] pcnt = 6'h00; // print progress
	logic [3:0] lcnt = 4'h0;  // lift travel
	logic       held = 1'b0;  // label sits on the pad
	// slow print so pickup outlasts the support on-delay
	always_ff @(posedge i_clk) begin
		pcnt <= i_print.print ? pcnt + 6'h01 : 6'h00;
		o_done <= i_print.print && pcnt == 6'h28;
		if (!i_valves.vacuum)
			held <= 1'b0;
		else if (o_done)
			held <= !i_no_label;
	end
	// pad reaches the product some cycles after the lift valve
	always_ff @(posedge i_clk) begin
		lcnt <= !i_valves.lift ? 4'h0 : (lcnt == 4'hF ? lcnt : lcnt + 4'h1);
	end
	assign o_pos = lcnt > 4'h3;
	// no label means the suction holes stay open
	assign o_vac = i_valves.vacuum && held;
endmodule : lacs_partner

// file: test/lacs_sequencer_assertions.sv
`timescale 1ns/100ps
// port checker for the labelling sequencer
module lacs_sequencer_assertions
	import lacs_pkg::*;
#(
	parameter int unsigned TICK_DIV = TICK_CYCLES
) (
	// clock, reset and apb
	input wire logic        i_clk,
	input wire logic        i_reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pins
	input wire logic        i_start,
	input wire logic        i_prime,
	input wire logic        i_pos_sensor,
	input wire logic        i_vac_sensor,
	input wire logic        i_print_done,
	input lacs_print_t      o_print,
	input lacs_valves_t     o_valves,
	input wire logic        o_pad_empty
);
	logic [31:0] ctrl_q;  // shadow of the mode bits
	logic        sup_big; // on-delay of two ticks or more
	logic [7:0]  pcfg;    // shadow peel values
	logic [7:0]  pjob;
	logic        apw;     // write taken at this edge
	assign apw = psel && penable && pwrite && pready;
	// shadows follow taken writes only
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ctrl_q <= CTRL_RST;
			sup_big <= 1'b0;
			pcfg <= 8'h00;
			pjob <= 8'h00;
		end else if (apw) begin
			if (paddr == OFS_CTRL) ctrl_q <= pwdata;
			if (paddr == OFS_SUP_ON) sup_big <= |pwdata[TIME_W-1:1];
			if (paddr == OFS_PEEL_CFG) pcfg <= pwdata[7:0];
			if (paddr == OFS_PEEL_JOB) pjob <= pwdata[7:0];
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	peel_sum_a: assert property (apw && paddr >= OFS_PEEL_CFG |->
		##2 o_print.peel == pcfg + pjob) else $error("peel not summed");
	bf_gated_a: assert property (o_print.backfeed |->
		ctrl_q[CTRL_VAC_CHK]) else $error("backfeed with check off");
	bf_err_a: assert property (o_print.backfeed |=>
		!o_print.backfeed && o_pad_empty) else $error("backfeed no error");
	err_hold_a: assert property (o_pad_empty && !(apw &&
		paddr == OFS_CMD && pwdata[CMD_CLR_ERR]) |=> o_pad_empty)
		else $error("error dropped");
	print_hold_a: assert property (o_print.print && !i_print_done
		|=> o_print.print) else $error("print dropped early");
	vac_print_a: assert property ($rose(o_print.print) |->
		o_valves.vacuum) else $error("print without vacuum");
	sup_late_a: assert property ($rose(o_print.print) && sup_big
		|-> !o_valves.support) else $error("support air too early");
	stamp_up_a: assert property (ctrl_q[1:0] == LACS_STAMP &&
		o_valves.lift && i_pos_sensor |-> ##[1:6] !o_valves.lift)
		else $error("pad not raised");
	vac_off_a: assert property (ctrl_q[1:0] == LACS_STAMP &&
		o_valves.lift && i_pos_sensor |-> ##[0:5] !o_valves.vacuum)
		else $error("vacuum kept at product");
	lower_late_a: assert property (!ctrl_q[CTRL_APRINT] &&
		$rose(o_valves.lift) |-> !o_print.print) else $error("early lower");
	bf_c: cover property (o_print.backfeed);
	blow_c: cover property ($rose(o_valves.blow));
	dwell_c: cover property (ctrl_q[1:0] == LACS_ROLL && i_pos_sensor);
endmodule : lacs_sequencer_assertions
bind lacs_sequencer lacs_sequencer_assertions #(.TICK_DIV(TICK_DIV)) chk_u (
	.i_clk, .i_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .i_start, .i_prime, .i_pos_sensor, .i_vac_sensor,
	.i_print_done, .o_print, .o_valves, .o_pad_empty);

// file: test/lacs_sequencer_tb_top.sv
`timescale 1ns/100ps
// bench: apb master, pad model and one task per scenario
module lacs_sequencer_tb_top;
	import lacs_pkg::*;
	logic         i_clk, i_reset, psel, penable, pwrite, pready, pslverr;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, rq; // rq: last word read
	logic         i_start, i_prime, i_pos_sensor, i_vac_sensor, re;
	logic         i_print_done, o_pad_empty, no_label;
	lacs_print_t  o_print;
	lacs_valves_t o_valves;
	int           n_fail, check_count, cyc, t_st, t_pr, t_su, t_sf;
	int           t_bl, t_dn, n_pr, n_bl, n_dw, n_bf; // cycle stamps and counts
	logic         pr_q, su_q, bl_q; // previous output levels
	// ten cycles a tick keeps every delay short
	lacs_sequencer #(.TICK_DIV(10)) dut_u (.i_clk, .i_reset, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.i_start, .i_prime, .i_pos_sensor, .i_vac_sensor, .i_print_done,
		.o_print, .o_valves, .o_pad_empty);
	lacs_partner pm_u (.i_clk, .i_print(o_print), .i_valves(o_valves),
		.i_no_label(no_label), .o_pos(i_pos_sensor), .o_vac(i_vac_sensor),
		.o_done(i_print_done));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// stamps and counts of what the design drives
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		{pr_q, su_q, bl_q} <= {o_print.print, o_valves.support, o_valves.blow};
		if (o_print.print && !pr_q) t_pr <= cyc;
		if (o_print.print && !pr_q) n_pr <= n_pr + 1;
		if (o_valves.support && !su_q) t_su <= cyc;
		if (su_q && !o_valves.support) t_sf <= cyc;
		if (o_valves.blow && !bl_q) t_bl <= cyc;
		if (o_valves.blow) n_bl <= n_bl + 1;
		if (o_valves.lift && i_pos_sensor) n_dw <= n_dw + 1;
		if (o_print.backfeed) n_bf <= n_bf + 1;
		if (i_print_done) t_dn <= cyc;
	end
	// one apb transfer; the request holds until pready is sampled
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rng(input int v, input int lo, input int hi);
		check_count++;
		if (v < lo || v > hi) begin
			n_fail++;
			$display("[ERR] %0t count %0d not in %0d..%0d", $time, v, lo, hi);
		end
	endtask : rng
	// pin pulse long enough for the synchroniser; counts restart
	task automatic pulse(input logic prime);
		@(posedge i_clk);
		i_start <= !prime;
		i_prime <= prime;
		t_st = cyc;
		{n_pr, n_bl, n_dw, n_bf} = '0;
		repeat (4) @(posedge i_clk);
		i_start <= 1'b0;
		i_prime <= 1'b0;
	endtask : pulse
	// poll state until idle, bounded
	task automatic idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, OFS_STATUS, 32'h0);
			n++;
		end while (rq[3:0] !== 4'h0 && n < 300);
		chk({28'h0, rq[3:0]}, 32'h0);
	endtask : idle
	task automatic s_regs();
		chk({28'h0, o_valves}, 32'h0);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(rq, CTRL_RST);
		apb(1'b0, OFS_SUP_OFF, 32'h0);
		chk(rq, 32'(270 / TICK_MS));
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, re}, 32'h1);
		apb(1'b1, OFS_PEEL_CFG, 32'h0000_00FE);
		apb(1'b1, OFS_PEEL_JOB, 32'h0000_0005);
		repeat (3) @(posedge i_clk);
		chk({24'h0, o_print.peel}, 32'h3);
		apb(1'b0, OFS_PEEL_CFG, 32'h0);
		chk({24'h0, rq[7:0]}, 32'hFE);
		apb(1'b1, OFS_PEEL_JOB, 32'h0);
		repeat (3) @(posedge i_clk);
		chk({24'h0, o_print.peel}, 32'hFE);
	endtask : s_regs
	// stamp cycle: start delay, support timing, lock-out
	task automatic s_stamp();
		apb(1'b1, OFS_SUP_ON, 32'h2);
		apb(1'b1, OFS_SUP_OFF, 32'h2);
		apb(1'b1, OFS_START_DLY, 32'h4);
		apb(1'b1, OFS_LOCK, 32'h1E);
		pulse(1'b0);
		idle();
		rng(t_pr - t_st, 33, 50);
		rng(t_su - t_pr, 9, 22);
		rng(t_sf - t_dn, 9, 25);
		pulse(1'b0);
		repeat (60) @(posedge i_clk);
		chk(n_pr, 32'h0);
		repeat (300) @(posedge i_clk);
		apb(1'b1, OFS_LOCK, 32'h0);
		pulse(1'b0);
		idle();
		chk(n_pr, 32'h1);
		apb(1'b1, OFS_START_DLY, 32'h0);
	endtask : s_stamp
	// empty pad with the check on, then off
	task automatic s_vac();
		int n;
		no_label <= 1'b1;
		pulse(1'b0);
		n = 0;
		while (o_pad_empty !== 1'b1 && n < 400) begin
			@(posedge i_clk);
			n++;
		end
		repeat (4) @(posedge i_clk);
		chk(n_bf, 32'h1);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk({31'h0, rq[4]}, 32'h1);
		apb(1'b1, OFS_CMD, 32'h1);
		apb(1'b1, OFS_CTRL, 32'h0);
		chk({31'h0, o_pad_empty}, 32'h0);
		pulse(1'b0);
		idle();
		chk({31'h0, o_pad_empty}, 32'h0);
		chk(n_bf, 32'h0);
		no_label <= 1'b0;
	endtask : s_vac
	// roll with apply-print: park bit ignored, dwell timed
	task automatic s_roll();
		apb(1'b1, OFS_ROLL, 32'h5);
		apb(1'b1, OFS_CTRL, 32'h1E);
		pulse(1'b1);
		idle();
		chk(n_pr, 32'h1);
		chk({31'h0, o_valves.lift}, 32'h0);
		pulse(1'b0);
		idle();
		rng(n_dw, 40, 60);
		chk(n_pr, 32'h1);
	endtask : s_roll
	// blow with apply-print parked low
	task automatic s_blow();
		apb(1'b1, OFS_BLOW, 32'h3);
		apb(1'b1, OFS_CTRL, 32'h1D);
		pulse(1'b0);
		idle();
		chk({31'h0, o_valves.lift}, 32'h1);
		pulse(1'b0);
		idle();
		rng(t_bl - t_st, 3, 8);
		rng(n_bl, 20, 32);
		chk(n_pr, 32'h1);
	endtask : s_blow
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	initial begin
		{i_reset, psel, penable, pwrite, i_start, i_prime} = 6'h20;
		{paddr, pwdata, no_label} = '0;
		repeat (16) @(posedge i_clk);
		i_reset <= 1'b0;
		s_regs();
		s_stamp();
		s_vac();
		s_roll();
		s_blow();
		finish_test();
	end
	// hang guard, far beyond the scenarios' length
	initial begin
		repeat (40000) @(posedge i_clk);
		n_fail++;
		finish_test();
	end
endmodule : lacs_sequencer_tb_top
